// >>> tss_pkg.sv
// Constants, field layout and types shared by the tilt sensor serial slave
package tss_pkg;

	// Sample and command widths
	localparam int ACCEL_W = 11;
	localparam int TEMP_W = 8;
	localparam int CMD_W = 8;
	localparam int CMD_CNT_W = 3;
	localparam int TX_CNT_W = 4;

	// Packed converter word: {temperature, channel 2, channel 1}
	localparam int CH1_LSB = 0;
	localparam int CH2_LSB = 11;
	localparam int TEMP_LSB = 22;
	localparam int SAMPLE_W = 30;

	// Command codes
	localparam logic [7:0] MEASURE_MODE_CMD = 8'h00;
	localparam logic [7:0] READ_TEMPERATURE_CMD = 8'h08;
	localparam logic [7:0] SELF_TEST_CH1_CMD = 8'h0E;
	localparam logic [7:0] SELF_TEST_CH2_CMD = 8'h0F;
	localparam logic [7:0] READ_ACCEL_CH1_CMD = 8'h10;
	localparam logic [7:0] READ_ACCEL_CH2_CMD = 8'h11;

	// Sample register reset values and output limits
	localparam logic [10:0] ACCEL_RESET = 11'h400;
	localparam logic [7:0] TEMP_RESET = 8'h00;
	localparam logic [10:0] ACCEL_RANGE_MIN = 11'h066;
	localparam logic [10:0] ACCEL_RANGE_MAX = 11'h799;
	localparam logic [10:0] ACCEL_FAIL_LOW = 11'h000;
	localparam logic [10:0] ACCEL_FAIL_HIGH = 11'h7FF;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RELOAD_PERIOD_NS = 150000;
	localparam int RELOAD_CYCLES = RELOAD_PERIOD_NS / CLK_PERIOD_NS;

	// Buffering
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0]
	{
		SPI_IDLE,
		SPI_CMD,
		SPI_DATA,
		SPI_BAD
	} tss_spi_state_type;

endpackage : tss_pkg

// >>> tss_fifo_if.sv
// Valid/ready carrier between the slave and its sample FIFO
`timescale 1ns/10ps
`default_nettype none
interface tss_fifo_if
#(
	parameter int WIDTH = 30
);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;

	modport store
	(
		input in_valid,
		input in_data,
		input out_ready,
		output in_ready,
		output out_valid,
		output out_data
	);

	modport user
	(
		output in_valid,
		output in_data,
		output out_ready,
		input in_ready,
		input out_valid,
		input out_data
	);
endinterface : tss_fifo_if
`default_nettype wire

// >>> tss_fifo.sv
// Sample FIFO with registered read data and registered input ready
`timescale 1ns/10ps
`default_nettype none
module tss_fifo
	import tss_pkg::*;
#(
	parameter int WIDTH = SAMPLE_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Both sides
	tss_fifo_if.store port
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic in_ready_r;
	logic out_valid_r;
	logic [WIDTH-1:0] out_data_r;

	wire push = port.in_valid & in_ready_r;
	// Refill the output register when it is empty or being taken
	wire pop = (count_r != '0) & (~out_valid_r | port.out_ready);

	assign count_nxt = count_r + CW'(push) - CW'(pop);
	assign port.in_ready = in_ready_r;
	assign port.out_valid = out_valid_r;
	assign port.out_data = out_data_r;

	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr_r] <= port.in_data;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			in_ready_r <= 1'b0;
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + PW'(1);
			if (pop)
			begin
				rd_ptr_r <= rd_ptr_r + PW'(1);
				out_data_r <= mem[rd_ptr_r];
				out_valid_r <= 1'b1;
			end
			else if (port.out_ready)
				out_valid_r <= 1'b0;
			count_r <= count_nxt;
			in_ready_r <= (count_nxt < CW'(DEPTH));
		end
	end

endmodule : tss_fifo
`default_nettype wire

// >>> tss_spi_slave.sv
// Serial slave of a dual-channel tilt sensor with sample registers
`timescale 1ns/10ps
`default_nettype none
module tss_spi_slave
	import tss_pkg::*;
#(
	parameter int RELOAD_COUNT = RELOAD_CYCLES,
	parameter int SAMPLE_DEPTH = FIFO_DEPTH
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Serial pins
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe_n,
	// Self test pins
	input wire logic self_test_pin_ch1,
	input wire logic self_test_pin_ch2,
	// Converter samples
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	output logic sample_ready,
	// Failure detection
	input wire logic interconnect_fail,
	input wire logic parity_error,
	output logic nvm_reload,
	output logic memory_fault,
	// Mode
	output logic self_test_ch1_en,
	output logic self_test_ch2_en,
	output logic measure_mode
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [ACCEL_W-1:0] shape_accel
	(
		input logic [ACCEL_W-1:0] raw,
		input logic link_fail,
		input logic mem_fail
	);
		logic [ACCEL_W-1:0] v;
		v = raw;
		if (mem_fail)
			v = ACCEL_FAIL_LOW;
		else if (link_fail)
			v = ACCEL_FAIL_HIGH;
		else if (raw < ACCEL_RANGE_MIN)
			v = ACCEL_RANGE_MIN;
		else if (raw > ACCEL_RANGE_MAX)
			v = ACCEL_RANGE_MAX;
		return v;
	endfunction : shape_accel

	localparam int RCW = $clog2(RELOAD_COUNT + 1);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0] sck_sync_r;
	logic [1:0] cs_sync_r;
	logic [1:0] mosi_sync_r;
	logic [1:0] st1_sync_r;
	logic [1:0] st2_sync_r;
	logic sck_prev_r;
	logic cs_prev_r;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sck_sync_r <= 2'h0;
			cs_sync_r <= 2'h3;
			mosi_sync_r <= 2'h0;
			st1_sync_r <= 2'h0;
			st2_sync_r <= 2'h0;
			sck_prev_r <= 1'b0;
			cs_prev_r <= 1'b1;
		end
		else
		begin
			sck_sync_r <= {sck_sync_r[0], sclk};
			cs_sync_r <= {cs_sync_r[0], chip_select_n};
			mosi_sync_r <= {mosi_sync_r[0], mosi};
			st1_sync_r <= {st1_sync_r[0], self_test_pin_ch1};
			st2_sync_r <= {st2_sync_r[0], self_test_pin_ch2};
			sck_prev_r <= sck_sync_r[1];
			cs_prev_r <= cs_sync_r[1];
		end
	end

	wire sck_s = sck_sync_r[1];
	wire cs_n_s = cs_sync_r[1];
	wire mosi_s = mosi_sync_r[1];
	wire sck_rise = sck_s & ~sck_prev_r;
	wire sck_fall = ~sck_s & sck_prev_r;
	wire cs_fall = ~cs_n_s & cs_prev_r;
	wire cs_rise = cs_n_s & ~cs_prev_r;

	////////////////////////////////////////////////////////////////////////
	// Sample FIFO and periodic reload

	tss_fifo_if #(.WIDTH(SAMPLE_W)) fifo_bus ();

	tss_fifo
	#(
		.WIDTH(SAMPLE_W),
		.DEPTH(SAMPLE_DEPTH)
	)
	i_tss_fifo
	(
		.clock(clock),
		.rst(rst),
		.port(fifo_bus.store)
	);

	logic [RCW-1:0] reload_cnt_r;
	logic [ACCEL_W-1:0] channel1_accel_sample_r;
	logic [ACCEL_W-1:0] channel2_accel_sample_r;
	logic [TEMP_W-1:0] temperature_sample_r;
	tss_spi_state_type state_r;
	tss_spi_state_type state_nxt;

	wire reload_tick = (reload_cnt_r == RCW'(RELOAD_COUNT - 1));
	// Only pull a sample while deselected, so a read never sees a torn word
	wire reload_take = reload_tick & cs_n_s & (state_r == SPI_IDLE)
		& fifo_bus.out_valid;

	assign fifo_bus.in_valid = sample_valid;
	assign fifo_bus.in_data = sample_data;
	assign fifo_bus.out_ready = reload_take;
	// Ready is a flop inside the FIFO, so the stall reaches the converter
	assign sample_ready = fifo_bus.in_ready;

	always_ff @(posedge clock)
	begin
		if (rst || reload_tick)
			reload_cnt_r <= '0;
		else
			reload_cnt_r <= reload_cnt_r + RCW'(1);
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			channel1_accel_sample_r <= ACCEL_RESET;
			channel2_accel_sample_r <= ACCEL_RESET;
			temperature_sample_r <= TEMP_RESET;
		end
		else if (reload_take)
		begin
			channel1_accel_sample_r <=
				fifo_bus.out_data[CH1_LSB +: ACCEL_W];
			channel2_accel_sample_r <=
				fifo_bus.out_data[CH2_LSB +: ACCEL_W];
			temperature_sample_r <=
				fifo_bus.out_data[TEMP_LSB +: TEMP_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Failure detection

	logic parity_seen_r;
	logic nvm_reload_r;
	logic memory_fault_r;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			parity_seen_r <= 1'b0;
			nvm_reload_r <= 1'b0;
			memory_fault_r <= 1'b0;
		end
		else
		begin
			nvm_reload_r <= parity_error & ~parity_seen_r;
			if (parity_error)
				parity_seen_r <= 1'b1;
			if (parity_error && parity_seen_r)
				memory_fault_r <= 1'b1;
		end
	end

	assign nvm_reload = nvm_reload_r;
	assign memory_fault = memory_fault_r;

	////////////////////////////////////////////////////////////////////////
	// Command decode

	logic [CMD_W-1:0] cmd_r;
	logic [CMD_CNT_W-1:0] bit_cnt_r;
	logic [ACCEL_W-1:0] tx_r;
	logic [TX_CNT_W-1:0] tx_left_r;

	// The byte as it stands once the eighth bit is in
	wire [CMD_W-1:0] cmd_full = {cmd_r[CMD_W-2:0], mosi_s};
	wire cmd_last = (state_r == SPI_CMD) & sck_rise
		& (bit_cnt_r == CMD_CNT_W'(CMD_W - 1));
	wire is_measure_mode_cmd = (cmd_full == MEASURE_MODE_CMD);
	wire is_temp = (cmd_full == READ_TEMPERATURE_CMD);
	wire is_st1 = (cmd_full == SELF_TEST_CH1_CMD);
	wire is_st2 = (cmd_full == SELF_TEST_CH2_CMD);
	wire is_acc1 = (cmd_full == READ_ACCEL_CH1_CMD);
	wire is_acc2 = (cmd_full == READ_ACCEL_CH2_CMD);
	wire cmd_valid = is_measure_mode_cmd | is_temp | is_st1 | is_st2 | is_acc1 | is_acc2;

	wire [ACCEL_W-1:0] acc1_out = shape_accel(channel1_accel_sample_r,
		interconnect_fail, memory_fault_r);
	wire [ACCEL_W-1:0] acc2_out = shape_accel(channel2_accel_sample_r,
		interconnect_fail, memory_fault_r);

	// Temperature sits left-aligned so the same MSB tap serves both widths
	wire [ACCEL_W-1:0] tx_load =
		is_temp ? {temperature_sample_r, (ACCEL_W - TEMP_W)'(0)} :
		is_acc1 ? acc1_out :
		is_acc2 ? acc2_out :
		'0;
	wire [TX_CNT_W-1:0] tx_len =
		is_temp ? TX_CNT_W'(TEMP_W) :
		(is_acc1 | is_acc2) ? TX_CNT_W'(ACCEL_W) :
		'0;

	////////////////////////////////////////////////////////////////////////
	// Transaction state

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			SPI_IDLE:
			begin
				if (cs_fall)
					state_nxt = SPI_CMD;
			end
			SPI_CMD:
			begin
				if (cs_n_s)
					state_nxt = SPI_IDLE;
				else if (cmd_last)
					state_nxt = cmd_valid ? SPI_DATA : SPI_BAD;
			end
			SPI_DATA:
			begin
				if (cs_n_s)
					state_nxt = SPI_IDLE;
			end
			SPI_BAD:
			begin
				// Only a fresh select restarts the link
				if (cs_n_s)
					state_nxt = SPI_IDLE;
			end
			default:
				state_nxt = SPI_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			state_r <= SPI_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clock)
	begin
		if (rst || cs_n_s || cs_rise)
		begin
			cmd_r <= '0;
			bit_cnt_r <= '0;
		end
		else if (state_r == SPI_CMD && sck_rise)
		begin
			cmd_r <= cmd_full;
			bit_cnt_r <= bit_cnt_r + CMD_CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output shifter

	logic miso_r;
	logic miso_oe_n_r;

	always_ff @(posedge clock)
	begin
		if (rst || cs_n_s)
		begin
			tx_r <= '0;
			tx_left_r <= '0;
			miso_r <= 1'b0;
		end
		else if (cmd_last)
		begin
			tx_r <= tx_load;
			tx_left_r <= tx_len;
		end
		else if (state_r == SPI_DATA && sck_fall)
		begin
			// Input bits in this phase are clocked but never stored
			if (tx_left_r != '0)
			begin
				miso_r <= tx_r[ACCEL_W-1];
				tx_r <= {tx_r[ACCEL_W-2:0], 1'b0};
				tx_left_r <= tx_left_r - TX_CNT_W'(1);
			end
			else
				miso_r <= 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			miso_oe_n_r <= 1'b1;
		else
			miso_oe_n_r <= cs_n_s | (state_nxt == SPI_BAD)
				| (state_nxt == SPI_IDLE);
	end

	assign miso = miso_r;
	assign miso_oe_n = miso_oe_n_r;

	////////////////////////////////////////////////////////////////////////
	// Self test and mode

	logic st_cmd_ch1_r;
	logic st_cmd_ch2_r;
	logic self_test_ch1_en_r;
	logic self_test_ch2_en_r;
	logic measure_mode_r;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_cmd_ch1_r <= 1'b0;
			st_cmd_ch2_r <= 1'b0;
		end
		else if (cmd_last)
		begin
			if (is_measure_mode_cmd)
			begin
				st_cmd_ch1_r <= 1'b0;
				st_cmd_ch2_r <= 1'b0;
			end
			if (is_st1)
				st_cmd_ch1_r <= 1'b1;
			if (is_st2)
				st_cmd_ch2_r <= 1'b1;
		end
	end

	// Both channels may show enabled if the master breaks the one-at-a-time
	// limit; the block passes that through rather than guessing a winner
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			self_test_ch1_en_r <= 1'b0;
			self_test_ch2_en_r <= 1'b0;
			measure_mode_r <= 1'b1;
		end
		else
		begin
			self_test_ch1_en_r <= st_cmd_ch1_r | st1_sync_r[1];
			self_test_ch2_en_r <= st_cmd_ch2_r | st2_sync_r[1];
			measure_mode_r <= ~(st_cmd_ch1_r | st1_sync_r[1]
				| st_cmd_ch2_r | st2_sync_r[1]);
		end
	end

	assign self_test_ch1_en = self_test_ch1_en_r;
	assign self_test_ch2_en = self_test_ch2_en_r;
	assign measure_mode = measure_mode_r;

endmodule : tss_spi_slave
`default_nettype wire

// >>> tss_spi_slave_asserts.sv
// Port-level checker for the tilt sensor serial slave
`timescale 1ns/10ps
`default_nettype none
module tss_spi_slave_asserts
	import tss_pkg::*;
#(
	parameter int RELOAD_COUNT = RELOAD_CYCLES,
	parameter int SAMPLE_DEPTH = FIFO_DEPTH
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Serial pins
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe_n,
	// Self test pins
	input wire logic self_test_pin_ch1,
	input wire logic self_test_pin_ch2,
	// Samples
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	input wire logic sample_ready,
	// Failures
	input wire logic interconnect_fail,
	input wire logic parity_error,
	input wire logic nvm_reload,
	input wire logic memory_fault,
	// Mode
	input wire logic self_test_ch1_en,
	input wire logic self_test_ch2_en,
	input wire logic measure_mode
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Remembers a first parity error so the second one can be told apart
	logic seen_r;
	logic seen_nxt;
	assign seen_nxt = seen_r | parity_error;
	always_ff @(posedge clock)
	begin
		if (rst)
			seen_r <= 1'b0;
		else
			seen_r <= seen_nxt;
	end
	////////////////////////////////////////////////////////////////////////
	// Allows for the synchroniser delay before the pin floats
	property p_oe_idle;
		chip_select_n [*8] |-> miso_oe_n;
	endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("output driven while deselected");
	property p_oe_fall;
		$fell(miso_oe_n) |-> !chip_select_n && !$past(chip_select_n, 2);
	endproperty
	a_oe_fall: assert property (p_oe_fall)
		else $error("output enabled outside a frame");
	property p_miso_hold;
		sclk [*6] |-> $stable(miso);
	endproperty
	a_miso_hold: assert property (p_miso_hold)
		else $error("serial output moved while clock high");
	property p_pin_st;
		self_test_pin_ch1 [*6] |-> self_test_ch1_en;
	endproperty
	a_pin_st: assert property (p_pin_st)
		else $error("self test pin ignored");
	property p_measure;
		(self_test_ch1_en || self_test_ch2_en) [*2] |-> !measure_mode;
	endproperty
	a_measure: assert property (p_measure)
		else $error("measure mode during self test");
	property p_measure_mode_cmd_back;
		(!self_test_ch1_en && !self_test_ch2_en) [*2] |-> measure_mode;
	endproperty
	a_measure_mode_cmd_back: assert property (p_measure_mode_cmd_back)
		else $error("measure mode missing");
	property p_reload;
		parity_error && !seen_r |=> nvm_reload;
	endproperty
	a_reload: assert property (p_reload)
		else $error("no reload after first parity error");
	property p_fault;
		parity_error && seen_r |=> memory_fault;
	endproperty
	a_fault: assert property (p_fault)
		else $error("no fault after second parity error");
	property p_no_reload;
		nvm_reload |-> $past(parity_error) && !$past(seen_r);
	endproperty
	a_no_reload: assert property (p_no_reload)
		else $error("reload without a first parity error");
	c_fault: cover property (memory_fault);
	c_full: cover property (!sample_ready);
	c_st2: cover property (self_test_ch2_en);
endmodule : tss_spi_slave_asserts
bind tss_spi_slave tss_spi_slave_asserts #(.RELOAD_COUNT(RELOAD_COUNT),
	.SAMPLE_DEPTH(SAMPLE_DEPTH)) i_tss_spi_slave_asserts (.clock(clock),
	.rst(rst), .sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi),
	.miso(miso), .miso_oe_n(miso_oe_n), .sample_valid(sample_valid),
	.self_test_pin_ch1(self_test_pin_ch1), .sample_data(sample_data),
	.self_test_pin_ch2(self_test_pin_ch2), .sample_ready(sample_ready),
	.interconnect_fail(interconnect_fail), .parity_error(parity_error),
	.nvm_reload(nvm_reload), .memory_fault(memory_fault),
	.self_test_ch1_en(self_test_ch1_en), .measure_mode(measure_mode),
	.self_test_ch2_en(self_test_ch2_en));
`default_nettype wire

// >>> tss_spi_master.sv
// Serial master model that frames commands for the slave
`timescale 1ns/10ps
`default_nettype none
module tss_spi_master
#(
	// Link clock and gaps run scaled down together with the reload period
	parameter real HALF_NS = 62.5,
	parameter int GAP_NS = 3000
)
(
	// Driven pins
	output var logic sclk,
	output var logic chip_select_n,
	output var logic mosi,
	// Returned data
	input wire logic miso,
	input wire logic miso_oe_n
);
	initial
	begin
		sclk = 1'b0;
		chip_select_n = 1'b1;
		mosi = 1'b0;
	end
	// Holding select low stalls sample loading in the slave
	task automatic hold(input logic lvl);
		chip_select_n = lvl;
		mosi = ~mosi;
		#(GAP_NS);
	endtask : hold
	// A floating output reads back as the inverse of the last bit
	task automatic xfer(input logic [7:0] cmd, input int ncmd,
		input int ndat, output logic [11:0] rx, output logic drv);
		int i;
		rx = 12'h000;
		drv = 1'b0;
		chip_select_n = 1'b0;
		#500;
		for (i = 0; i < ncmd; i++)
		begin
			mosi = cmd[7 - i];
			#(HALF_NS) sclk = 1'b1;
			#(HALF_NS) sclk = 1'b0;
		end
		for (i = 0; i < ndat; i++)
		begin
			mosi = 1'b0;
			#(HALF_NS);
			rx = {rx[10:0], miso_oe_n ? ~rx[0] : miso};
			drv = drv | ~miso_oe_n;
			sclk = 1'b1;
			#(HALF_NS) sclk = 1'b0;
		end
		#500 chip_select_n = 1'b1;
		mosi = ~mosi;
		// Gap shortened together with the reload period
		#(GAP_NS);
	endtask : xfer
endmodule : tss_spi_master
`default_nettype wire

// >>> tss_spi_slave_test.sv
// Self-checking bench for the tilt sensor serial slave
`timescale 1ns/10ps
`default_nettype none
module tss_spi_slave_test
	import tss_pkg::*;
;
	localparam int RELOAD = 20;
	localparam int LIMIT = 60000;
	logic clock, rst, sclk, chip_select_n, mosi, miso, miso_oe_n;
	logic self_test_pin_ch1, self_test_pin_ch2, sample_valid, sample_ready;
	logic interconnect_fail, parity_error, nvm_reload, memory_fault;
	logic self_test_ch1_en, self_test_ch2_en, measure_mode, drv, took;
	logic [SAMPLE_W-1:0] sample_data;
	logic [11:0] rx;
	logic [7:0] st_cmd [4] = '{SELF_TEST_CH1_CMD, MEASURE_MODE_CMD,
		SELF_TEST_CH2_CMD, MEASURE_MODE_CMD};
	logic [2:0] st_exp [4] = '{3'h4, 3'h1, 3'h2, 3'h1};
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	int i, n;
	tss_spi_slave #(.RELOAD_COUNT(RELOAD), .SAMPLE_DEPTH(FIFO_DEPTH))
		i_tss_spi_slave (.clock(clock), .rst(rst), .sclk(sclk),
		.chip_select_n(chip_select_n), .mosi(mosi), .miso(miso),
		.miso_oe_n(miso_oe_n), .self_test_pin_ch1(self_test_pin_ch1),
		.self_test_pin_ch2(self_test_pin_ch2), .sample_valid(sample_valid),
		.sample_data(sample_data), .sample_ready(sample_ready),
		.interconnect_fail(interconnect_fail), .parity_error(parity_error),
		.nvm_reload(nvm_reload), .memory_fault(memory_fault),
		.self_test_ch1_en(self_test_ch1_en), .measure_mode(measure_mode),
		.self_test_ch2_en(self_test_ch2_en));
	tss_spi_master i_tss_spi_master (.sclk(sclk), .mosi(mosi),
		.chip_select_n(chip_select_n), .miso(miso), .miso_oe_n(miso_oe_n));
	////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({11'h000, got}, {11'h000, exp});
	endtask : chk_bit
	// One extra clock after the word must show the trailing zero
	task automatic rd(input logic [7:0] cmd, input int n, input logic [10:0] e);
		i_tss_spi_master.xfer(cmd, 8, n + 1, rx, drv);
		chk_word(rx, {e, 1'b0});
		chk_bit(drv, 1'b1);
	endtask : rd
	// Spaced pushes let the registered ready settle before it is read
	task automatic push(input logic [SAMPLE_W-1:0] w, output logic t);
		@(negedge clock);
		t = (sample_ready === 1'b1);
		sample_valid = 1'b1;
		sample_data = w;
		@(negedge clock);
		sample_valid = 1'b0;
		@(negedge clock);
	endtask : push
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			miscompares++;
			complete_run();
		end
	end
	initial
	begin
		rst = 1'b1;
		{self_test_pin_ch1, self_test_pin_ch2, sample_valid} = 3'h0;
		{interconnect_fail, parity_error} = 2'h0;
		sample_data = 30'h00000000;
		repeat (4) @(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		rd(READ_ACCEL_CH1_CMD, ACCEL_W, ACCEL_RESET);
		rd(READ_ACCEL_CH2_CMD, ACCEL_W, ACCEL_RESET);
		rd(READ_TEMPERATURE_CMD, TEMP_W, {3'h0, TEMP_RESET});
		$display("test reset done");
		i_tss_spi_master.xfer(READ_ACCEL_CH1_CMD, 4, 0, rx, drv);
		push({8'hC3, 11'h5A5, 11'h123}, took);
		repeat (60) @(negedge clock);
		rd(READ_ACCEL_CH1_CMD, ACCEL_W, 11'h123);
		rd(READ_ACCEL_CH2_CMD, ACCEL_W, 11'h5A5);
		rd(READ_TEMPERATURE_CMD, TEMP_W, 11'h0C3);
		push({8'h00, 11'h79A, 11'h065}, took);
		repeat (60) @(negedge clock);
		rd(READ_ACCEL_CH1_CMD, ACCEL_W, ACCEL_RANGE_MIN);
		rd(READ_ACCEL_CH2_CMD, ACCEL_W, ACCEL_RANGE_MAX);
		$display("test data done");
		i_tss_spi_master.xfer(8'h55, 8, ACCEL_W + 1, rx, drv);
		chk_bit(drv, 1'b0);
		rd(READ_ACCEL_CH2_CMD, ACCEL_W, ACCEL_RANGE_MAX);
		$display("test invalid done");
		// Never both channels at once: measure sits between them
		for (i = 0; i < 4; i++)
		begin
			i_tss_spi_master.xfer(st_cmd[i], 8, 0, rx, drv);
			chk_word({9'h000, self_test_ch1_en, self_test_ch2_en,
				measure_mode}, {9'h000, st_exp[i]});
		end
		// Each pin alone must enable its channel and leave measure mode
		for (i = 0; i < 2; i++)
		begin
			self_test_pin_ch1 = (i == 0);
			self_test_pin_ch2 = (i == 1);
			repeat (8) @(negedge clock);
			chk_word({9'h000, self_test_ch1_en, self_test_ch2_en,
				measure_mode}, {9'h000, st_exp[2 * i]});
			self_test_pin_ch1 = 1'b0;
			self_test_pin_ch2 = 1'b0;
			repeat (8) @(negedge clock);
		end
		$display("test modes done");
		i_tss_spi_master.hold(1'b0);
		n = 0;
		for (i = 0; i < 12; i++)
		begin
			push({8'h00, 11'h000, 11'h100 + 11'(i)}, took);
			if (took)
				n++;
		end
		chk_word(12'(n), 12'(FIFO_DEPTH + 1));
		i_tss_spi_master.hold(1'b1);
		chk_bit(sample_ready, 1'b1);
		rd(READ_ACCEL_CH1_CMD, ACCEL_W, 11'h108);
		$display("test buffer done");
		interconnect_fail = 1'b1;
		rd(READ_ACCEL_CH1_CMD, ACCEL_W, ACCEL_FAIL_HIGH);
		interconnect_fail = 1'b0;
		for (i = 0; i < 2; i++)
		begin
			@(negedge clock);
			parity_error = 1'b1;
			@(negedge clock);
			chk_bit(nvm_reload, i == 0);
			parity_error = 1'b0;
			repeat (3) @(negedge clock);
			chk_bit(memory_fault, i == 1);
		end
		rd(READ_ACCEL_CH1_CMD, ACCEL_W, ACCEL_FAIL_LOW);
		$display("test failure done");
		complete_run();
	end
endmodule : tss_spi_slave_test
`default_nettype wire
